// file: verilog/slbs_regs.vh
// Offsets, field positions, reset values and timing counts of the strap latch.
`ifndef SLBS_REGS_VH
`define SLBS_REGS_VH
// ************************************************************
// Register offsets
// ************************************************************
`define SLBS_OFF_STRAP     12'h000
`define SLBS_OFF_BOOT      12'h004
`define SLBS_OFF_FUSE      12'h008
`define SLBS_OFF_CTRL      12'h00c
// ************************************************************
// Field positions
// ************************************************************
`define SLBS_STRAP_GUARD   0
`define SLBS_STRAP_PRINT   1
`define SLBS_STRAP_BSEL    2
`define SLBS_STRAP_VALID   3
`define SLBS_BOOT_MODE_LSB 0
`define SLBS_BOOT_PRINT    2
`define SLBS_BOOT_ROUTE    3
`define SLBS_FUSE_USBROUTE 0
`define SLBS_FUSE_USBDIS   1
`define SLBS_FUSE_POL_LSB  2
`define SLBS_CTRL_DONE     0
`define SLBS_CTRL_SRAM     1
// ************************************************************
// Encodings and reset values
// ************************************************************
`define SLBS_MODE_NONE     2'h0
`define SLBS_MODE_FLASH    2'h1
`define SLBS_MODE_DL       2'h2
`define SLBS_MODE_INVALID  2'h3
`define SLBS_ROUTE_UART    1'b0
`define SLBS_ROUTE_USB     1'b1
`define SLBS_POL_ALWAYS    2'h0
`define SLBS_POL_WHEN0     2'h1
`define SLBS_POL_WHEN1     2'h2
`define SLBS_POL_NEVER     2'h3
`define SLBS_STRAP_RST     3'h4
// ************************************************************
// Timing
// ************************************************************
`define SLBS_CLK_MHZ       200
`define SLBS_HOLD_NS       1000
`define SLBS_HOLD_CYC      ((`SLBS_HOLD_NS * `SLBS_CLK_MHZ) / 1000)
`endif

// file: verilog/slbs_log_decode.v
// Boot mode and boot-ROM log route decoder for latched straps and fuses.
`include "slbs_regs.vh"
module slbs_log_decode (
   input  wire       bsel,
   input  wire       print_strap,
   input  wire       usb_route_fuse,
   input  wire       usb_disable_fuse,
   input  wire [1:0] policy_fuse,
   output reg  [1:0] boot_mode,
   output reg        log_enable,
   output reg        log_to_usb
);
   // ************************************************************
   // Decode
   // ************************************************************
   always @* begin
      // Glitch guard strap is deliberately not an input.
      if (bsel) begin
         boot_mode = `SLBS_MODE_FLASH;
      end else if (print_strap) begin
         boot_mode = `SLBS_MODE_DL;
      end else begin
         boot_mode = `SLBS_MODE_INVALID;
      end
      log_to_usb = 1'b0;
      log_enable = 1'b0;
      if (!usb_route_fuse && !usb_disable_fuse) begin
         log_to_usb = `SLBS_ROUTE_USB;
         log_enable = 1'b1;
      end else if (usb_disable_fuse) begin
         log_to_usb = `SLBS_ROUTE_UART;
         case (policy_fuse)
            `SLBS_POL_ALWAYS: log_enable = 1'b1;
            `SLBS_POL_WHEN0:  log_enable = ~print_strap;
            `SLBS_POL_WHEN1:  log_enable = print_strap;
            `SLBS_POL_NEVER:  log_enable = 1'b0;
            default:          log_enable = 1'b0;
         endcase
      end
   end
endmodule

// file: verilog/slbs_strap_latch.v
// Strap latch, boot select and log control with an APB register view.
// What this block does
// - Latch each strap level at reset and hold it until power-down.
// - Latched strap values never change by software or later pin activity.
// - After sampling, release strap pins to ordinary general-purpose use.
// - Weak pull-up on boot-select strap during reset; others have none.
// - Boot-select 1 gives flash boot; 0 with print strap 1 gives download.
// - Boot mode ignores the glitch-guard strap.
// - Flash boot mode makes the boot ROM load and run from flash.
// - Download mode accepts images over serial or USB, to flash or SRAM.
// - Logs go to USB port when route and disable fuses are both 0.
// - Disable fuse 1 routes logs to UART, gated by policy and strap.
// - Policy 0 always, 1 when strap 0, 2 when strap 1, 3 never.
// - Enable pin high runs the chip, low holds it shut down.
//
// Implementation choices: the register offsets and the APB slave port.
`include "slbs_regs.vh"
module slbs_strap_latch #(
   parameter HOLD_CYC = `SLBS_HOLD_CYC
) (
   input  wire        sys_clk,
   input  wire        reset_n,
   input  wire        glitch_guard_strap_in,
   input  wire        print_and_mode_strap_in,
   input  wire        boot_select_strap_in,
   input  wire        gpio_glitch_guard_out,
   input  wire        gpio_glitch_guard_oe,
   input  wire        gpio_print_mode_out,
   input  wire        gpio_print_mode_oe,
   input  wire        gpio_boot_select_out,
   input  wire        gpio_boot_select_oe,
   input  wire        rom_log_usb_route_fuse,
   input  wire        usb_debug_port_disable_fuse,
   input  wire [1:0]  uart_log_policy_fuse,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output reg  [31:0] prdata,
   output wire        pslverr,
   output wire        glitch_guard_strap_out,
   output wire        glitch_guard_strap_oe,
   output wire        print_and_mode_strap_out,
   output wire        print_and_mode_strap_oe,
   output wire        boot_select_strap_out,
   output wire        boot_select_strap_oe,
   output wire        boot_select_pullup_en,
   output reg         glitch_guard_strap,
   output reg         print_and_mode_strap,
   output reg         boot_select_strap,
   output reg         straps_valid,
   output reg  [1:0]  boot_mode,
   output wire        boot_from_flash,
   output wire        boot_download,
   output wire        download_image_sram,
   output reg         rom_log_enable,
   output reg         rom_log_to_usb,
   output reg         boot_done
);
   localparam CNT_W      = 16;
   localparam NUM_STRAPS = 3;
   localparam [31:0]      HOLD_LAST_W = HOLD_CYC - 1;
   localparam [CNT_W-1:0] HOLD_LAST   = HOLD_LAST_W[CNT_W-1:0];
   localparam ST_RESET = 2'd0;
   localparam ST_HOLD  = 2'd1;
   localparam ST_RUN   = 2'd2;

   reg  [1:0]       state_r;
   reg  [1:0]       state_nxt;
   reg  [CNT_W-1:0] hold_cnt_r;
   reg              sram_sel_r;
   wire [1:0]       dec_mode;
   wire             dec_log;
   wire             dec_usb;
   wire             pins_free;
   wire [NUM_STRAPS-1:0] gpio_out_w;
   wire [NUM_STRAPS-1:0] gpio_oe_w;
   wire [NUM_STRAPS-1:0] pad_out_w;
   wire [NUM_STRAPS-1:0] pad_oe_w;
   reg  [31:0]      rd_word;

   // ************************************************************
   // Sequencer
   // ************************************************************
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_RESET: state_nxt = ST_HOLD;
         ST_HOLD: begin
            if (hold_cnt_r == HOLD_LAST) begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN:   state_nxt = ST_RUN;
         default:  state_nxt = ST_RESET;
      endcase
   end

   always @(posedge sys_clk) begin
      if (!reset_n) begin
         // Low enable holds the block shut down.
         state_r    <= ST_RESET;
         hold_cnt_r <= {CNT_W{1'b0}};
      end else begin
         state_r <= state_nxt;
         if (state_r == ST_HOLD) begin
            hold_cnt_r <= hold_cnt_r + 1'b1;
         end
      end
   end

   // ************************************************************
   // Strap latches
   // ************************************************************
   always @(posedge sys_clk) begin
      if (!reset_n) begin
         straps_valid <= 1'b0;
      end else if (state_r == ST_RESET && !straps_valid) begin
         straps_valid <= 1'b1;
      end
   end

   always @(posedge sys_clk) begin
      // Captured once after release; nothing else writes these.
      if (reset_n && state_r == ST_RESET && !straps_valid) begin
         glitch_guard_strap   <= glitch_guard_strap_in;
         print_and_mode_strap <= print_and_mode_strap_in;
         boot_select_strap    <= boot_select_strap_in;
      end
   end

   // ************************************************************
   // Pin control
   // ************************************************************
   assign boot_select_pullup_en = !pins_free;
   assign pins_free = (state_r == ST_RUN);
   assign gpio_out_w[`SLBS_STRAP_GUARD] = gpio_glitch_guard_out;
   assign gpio_out_w[`SLBS_STRAP_PRINT] = gpio_print_mode_out;
   assign gpio_out_w[`SLBS_STRAP_BSEL]  = gpio_boot_select_out;
   assign gpio_oe_w[`SLBS_STRAP_GUARD]  = gpio_glitch_guard_oe;
   assign gpio_oe_w[`SLBS_STRAP_PRINT]  = gpio_print_mode_oe;
   assign gpio_oe_w[`SLBS_STRAP_BSEL]   = gpio_boot_select_oe;

   // Each strap pin stays undriven until the straps are latched and decoded.
   genvar pin_i;
   generate
      for (pin_i = 0; pin_i < NUM_STRAPS; pin_i = pin_i + 1) begin : g_pin
         assign pad_out_w[pin_i] = pins_free & gpio_out_w[pin_i];
         assign pad_oe_w[pin_i]  = pins_free & gpio_oe_w[pin_i];
      end
   endgenerate

   assign glitch_guard_strap_out   = pad_out_w[`SLBS_STRAP_GUARD];
   assign glitch_guard_strap_oe    = pad_oe_w[`SLBS_STRAP_GUARD];
   assign print_and_mode_strap_out = pad_out_w[`SLBS_STRAP_PRINT];
   assign print_and_mode_strap_oe  = pad_oe_w[`SLBS_STRAP_PRINT];
   assign boot_select_strap_out    = pad_out_w[`SLBS_STRAP_BSEL];
   assign boot_select_strap_oe     = pad_oe_w[`SLBS_STRAP_BSEL];

   // ************************************************************
   // Boot decode
   // ************************************************************
   slbs_log_decode u_dec (
      .bsel             (boot_select_strap),
      .print_strap      (print_and_mode_strap),
      .usb_route_fuse   (rom_log_usb_route_fuse),
      .usb_disable_fuse (usb_debug_port_disable_fuse),
      .policy_fuse      (uart_log_policy_fuse),
      .boot_mode        (dec_mode),
      .log_enable       (dec_log),
      .log_to_usb       (dec_usb)
   );

   always @(posedge sys_clk) begin
      if (!reset_n) begin
         boot_mode      <= `SLBS_MODE_NONE;
         rom_log_enable <= 1'b0;
         rom_log_to_usb <= 1'b0;
         boot_done      <= 1'b0;
      end else begin
         if (state_r == ST_HOLD) begin
            boot_mode      <= dec_mode;
            rom_log_enable <= dec_log;
            rom_log_to_usb <= dec_usb;
         end
         boot_done <= pins_free;
      end
   end

   assign boot_from_flash = boot_done &&
                            (boot_mode == `SLBS_MODE_FLASH);
   assign boot_download   = boot_done &&
                            (boot_mode == `SLBS_MODE_DL);
   assign download_image_sram = boot_download & sram_sel_r;

   // ************************************************************
   // APB slave
   // ************************************************************
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   // Address match, shared by the write path and the read path.
   function reg_hit;
      input [11:0] addr;
      input [11:0] offset;
      begin
         reg_hit = (addr == offset);
      end
   endfunction

   always @(posedge sys_clk) begin
      if (!reset_n) begin
         sram_sel_r <= 1'b0;
      end else if (psel && penable && pwrite &&
                   reg_hit(paddr, `SLBS_OFF_CTRL)) begin
         sram_sel_r <= pwdata[`SLBS_CTRL_SRAM];
      end
   end

   always @* begin
      rd_word = 32'h0000_0000;
      if (reg_hit(paddr, `SLBS_OFF_STRAP)) begin
         rd_word[`SLBS_STRAP_GUARD] = glitch_guard_strap;
         rd_word[`SLBS_STRAP_PRINT] = print_and_mode_strap;
         rd_word[`SLBS_STRAP_BSEL]  = boot_select_strap;
         rd_word[`SLBS_STRAP_VALID] = straps_valid;
      end
      if (reg_hit(paddr, `SLBS_OFF_BOOT)) begin
         rd_word[`SLBS_BOOT_MODE_LSB +: 2] = boot_mode;
         rd_word[`SLBS_BOOT_PRINT]         = rom_log_enable;
         rd_word[`SLBS_BOOT_ROUTE]         = rom_log_to_usb;
      end
      if (reg_hit(paddr, `SLBS_OFF_FUSE)) begin
         rd_word[`SLBS_FUSE_USBROUTE]     = rom_log_usb_route_fuse;
         rd_word[`SLBS_FUSE_USBDIS]       = usb_debug_port_disable_fuse;
         rd_word[`SLBS_FUSE_POL_LSB +: 2] = uart_log_policy_fuse;
      end
      if (reg_hit(paddr, `SLBS_OFF_CTRL)) begin
         rd_word[`SLBS_CTRL_DONE] = boot_done;
         rd_word[`SLBS_CTRL_SRAM] = sram_sel_r;
      end
   end

   // Read data is taken at the setup edge and stands through the access.
   always @(posedge sys_clk) begin
      if (!reset_n) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_word;
      end
   end
endmodule

// file: verif/slbs_strap_host.sv
// Strap pin model: host drive, weak pull-up and floating lines.
module slbs_strap_host (
   input  logic       sys_clk,
   input  logic       host_en,
   input  logic [2:0] host_val,
   input  logic [2:0] dut_oe,
   input  logic [2:0] dut_out,
   input  logic       pullup_en,
   output logic [2:0] pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic tog = 1'b0;
   always @(posedge sys_clk) tog <= ~tog;
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         if (dut_oe[i]) pin[i] = dut_out[i];
         else if (host_en) pin[i] = host_val[i];
         else if (i == 2 && pullup_en) pin[i] = 1'b1;
         else pin[i] = tog ^ i[0];
      end
   end
endmodule

// file: verif/slbs_strap_latch_assertions.sv
// Concurrent checks of strap capture, pin release and boot decode.
module slbs_strap_latch_assertions #(
   parameter HOLD_CYC = 200
) (
   input logic       sys_clk,
   input logic       reset_n,
   input logic       boot_select_strap_in,
   input logic       gpio_boot_select_out,
   input logic       gpio_boot_select_oe,
   input logic       rom_log_usb_route_fuse,
   input logic       usb_debug_port_disable_fuse,
   input logic [1:0] uart_log_policy_fuse,
   input logic       psel,
   input logic       pready,
   input logic       pslverr,
   input logic       boot_select_strap_out,
   input logic       boot_select_strap_oe,
   input logic       boot_select_pullup_en,
   input logic       print_and_mode_strap,
   input logic       boot_select_strap,
   input logic       straps_valid,
   input logic [1:0] boot_mode,
   input logic       boot_from_flash,
   input logic       boot_download,
   input logic       rom_log_enable,
   input logic       rom_log_to_usb,
   input logic       boot_done
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HMAX = HOLD_CYC + 4;
   logic pol_ok;
   assign pol_ok = (uart_log_policy_fuse == 2'h0) ||
      (uart_log_policy_fuse ==
       {print_and_mode_strap, ~print_and_mode_strap});
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   sequence s_rel; $rose(reset_n); endsequence
   sequence s_boot; !boot_done ##[1:HMAX] boot_done; endsequence
   AST_PULLUP: assert property (s_rel |-> boot_select_pullup_en)
      else $error("pull-up off at release");
   AST_CAPTURE: assert property (s_rel |=> straps_valid &&
      boot_select_strap == $past(boot_select_strap_in))
      else $error("strap not captured");
   AST_HOLD: assert property (
      straps_valid && $past(straps_valid) |->
      $stable({print_and_mode_strap, boot_select_strap}))
      else $error("latched strap changed");
   AST_NO_DRIVE: assert property (boot_select_pullup_en |->
      !boot_select_strap_oe) else $error("pin driven before release");
   AST_RELEASE: assert property (
      boot_done |-> !boot_select_pullup_en &&
      boot_select_strap_oe == gpio_boot_select_oe &&
      boot_select_strap_out == gpio_boot_select_out)
      else $error("pin not released");
   AST_BOOT_TIME: assert property (s_rel |-> s_boot)
      else $error("boot not done in time");
   AST_MODE: assert property (boot_done |-> boot_mode ==
      (boot_select_strap ? 2'h1 : (print_and_mode_strap ? 2'h2 : 2'h3)))
      else $error("boot mode wrong");
   AST_USB_LOG: assert property (
      boot_done && !usb_debug_port_disable_fuse |->
      rom_log_to_usb == !rom_log_usb_route_fuse &&
      rom_log_enable == !rom_log_usb_route_fuse)
      else $error("usb log wrong");
   AST_UART_LOG: assert property (
      boot_done && usb_debug_port_disable_fuse |->
      !rom_log_to_usb && rom_log_enable == pol_ok)
      else $error("uart log wrong");
   AST_BOOT_OUT: assert property (boot_done |->
      boot_from_flash == (boot_mode == 2'h1) &&
      boot_download == (boot_mode == 2'h2)) else $error("boot output wrong");
   AST_MODE_HOLD: assert property (boot_done && $past(boot_done) |->
      $stable(boot_mode)) else $error("boot mode changed");
   AST_APB_OK: assert property (psel |-> pready && !pslverr)
      else $error("bus answer wrong");
endmodule

// file: verif/tb_top.sv
// Self-checking bench for the strap latch and boot decode.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam HOLD_CYC = 4;
   // Enable-low time is scaled down in the same way as the hold time.
   localparam RST_CYC  = 2;
   logic        sys_clk = 1'b0, reset_n = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic [2:0]  g_out = 3'h0, g_oe = 3'h7, hv = 3'h0;
   wire  [2:0]  pin, d_out, d_oe;
   logic        host = 1'b1, rom_log_usb_route_fuse = 1'b0;
   logic        usb_debug_port_disable_fuse = 1'b0;
   logic [1:0]  uart_log_policy_fuse = 2'h0, boot_mode;
   logic        pready, pslverr, boot_select_pullup_en, glitch_guard_strap;
   logic        print_and_mode_strap, boot_select_strap, straps_valid;
   logic        boot_from_flash, boot_download, download_image_sram;
   logic        rom_log_enable, rom_log_to_usb, boot_done;
   int          n_errors = 0, tests_run = 0, cycles = 0;
   slbs_strap_host slbs_strap_host_inst (.sys_clk, .host_en(host),
      .host_val(hv), .dut_oe(d_oe), .dut_out(d_out),
      .pullup_en(boot_select_pullup_en), .pin);
   slbs_strap_latch #(.HOLD_CYC(HOLD_CYC)) slbs_strap_latch_inst (
      .sys_clk, .reset_n, .glitch_guard_strap_in(pin[0]),
      .print_and_mode_strap_in(pin[1]), .boot_select_strap_in(pin[2]),
      .gpio_glitch_guard_out(g_out[0]), .gpio_glitch_guard_oe(g_oe[0]),
      .gpio_print_mode_out(g_out[1]), .gpio_print_mode_oe(g_oe[1]),
      .gpio_boot_select_out(g_out[2]), .gpio_boot_select_oe(g_oe[2]),
      .rom_log_usb_route_fuse, .usb_debug_port_disable_fuse,
      .uart_log_policy_fuse, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pready, .prdata, .pslverr,
      .glitch_guard_strap_out(d_out[0]), .glitch_guard_strap_oe(d_oe[0]),
      .print_and_mode_strap_out(d_out[1]), .print_and_mode_strap_oe(d_oe[1]),
      .boot_select_strap_out(d_out[2]), .boot_select_strap_oe(d_oe[2]),
      .boot_select_pullup_en, .glitch_guard_strap, .print_and_mode_strap,
      .boot_select_strap, .straps_valid, .boot_mode, .boot_from_flash,
      .boot_download, .download_image_sram, .rom_log_enable,
      .rom_log_to_usb, .boot_done);
   always #2.5 sys_clk = ~sys_clk;
   task stop_test();
      if (n_errors == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_errors = n_errors + 1;
         stop_test();
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   initial begin
      logic [31:0] q;
      logic        bs, en, dis, rt;
      logic [1:0]  md;
      logic [3:0]  mk;
      for (int i = 0; i < 20; i++) begin
         @(posedge sys_clk);
         dis = i < 16;
         rt = i[0];
         reset_n <= 1'b0;
         host <= i < 18;
         hv <= i[2:0];
         g_out <= ~i[2:0];
         usb_debug_port_disable_fuse <= dis;
         rom_log_usb_route_fuse <= rt;
         uart_log_policy_fuse <= i[3:2];
         repeat (RST_CYC) @(posedge sys_clk);
         chk({boot_mode, boot_select_pullup_en, d_oe}, 6'h08);
         reset_n <= 1'b1;
         while (boot_done !== 1'b1) @(posedge sys_clk);
         host <= 1'b0;
         bs = (i < 18) ? i[2] : 1'b1;
         mk = (i < 18) ? 4'hf : 4'hc;
         md = bs ? 2'h1 : (i[1] ? 2'h2 : 2'h3);
         en = dis ? (i[3:2] == 0 || i[3:2] == {i[1], ~i[1]}) : ~rt;
         chk(boot_select_strap, bs);
         chk({print_and_mode_strap, glitch_guard_strap} & mk[1:0],
             i[1:0] & mk[1:0]);
         chk(boot_mode, md);
         chk({rom_log_to_usb, rom_log_enable}, {~dis & ~rt, en});
         chk({boot_from_flash, boot_download}, {md == 1, md == 2});
         apb(1'b1, 12'h000, 32'hffff_ffff, q);
         chk({d_oe, d_out}, {3'h7, ~i[2:0]});
         apb(1'b0, 12'h000, 32'h0000_0000, q);
         chk(q[3:0] & mk, {1'b1, bs, i[1:0]} & mk);
         apb(1'b0, 12'h004, 32'h0000_0000, q);
         chk(q, {~dis & ~rt, en, md});
         apb(1'b1, 12'h00c, 32'h0000_0002, q);
         apb(1'b0, 12'h00c, 32'h0000_0000, q);
         chk(q, 32'h0000_0003);
         chk(download_image_sram, md == 2);
         apb(1'b0, 12'h010, 32'h0000_0000, q);
         chk(q, 32'h0000_0000);
      end
      stop_test();
   end
endmodule
bind slbs_strap_latch slbs_strap_latch_assertions #(.HOLD_CYC(HOLD_CYC))
   slbs_strap_latch_assertions_inst (.sys_clk, .reset_n,
   .boot_select_strap_in, .gpio_boot_select_out, .gpio_boot_select_oe,
   .rom_log_usb_route_fuse, .usb_debug_port_disable_fuse,
   .uart_log_policy_fuse, .psel, .pready, .pslverr, .boot_select_strap_out,
   .boot_select_strap_oe, .boot_select_pullup_en, .print_and_mode_strap,
   .boot_select_strap, .straps_valid, .boot_mode, .boot_from_flash,
   .boot_download, .rom_log_enable, .rom_log_to_usb, .boot_done);
